//--- rtl/dep_consts.svh
// constants for the debug entry and program counter block
// assumes byte addresses and a 32-bit program counter
`ifndef DEP_CONSTS_SVH
`define DEP_CONSTS_SVH

`define DEP_BKPT_WORD_ADV 32'h0000_0010
`define DEP_BKPT_HALF_ADV 32'h0000_0008
`define DEP_WORD_ADDR     32'h0000_0004
`define DEP_HALF_ADDR     32'h0000_0002
`define DEP_BYTE_ADV      32'h0000_0004
`define DEP_DBG_STEP      32'h0000_0004
`define DEP_SYS_STEP      32'h0000_0014
`define DEP_VEC_ENTRY     32'h0000_0010
`define DEP_PC_RST        32'h0000_0000

`endif

//--- rtl/dep_debug_entry.sv
// debug entry, halt and return program counter control of the core
// assumes core event inputs are on core_clk; ext_dbg_req is an asynchronous pin
`timescale 1ns/1ps
`include "dep_consts.svh"

module dep_debug_entry
    import dep_pkg::*;
#(
    parameter logic [31:0] PABT_VEC = 32'h0000_000C,
    parameter logic [31:0] DABT_VEC = 32'h0000_0010,
    parameter logic [31:0] IRQ_VEC  = 32'h0000_0018
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        ext_dbg_req,
    input  wire logic [1:0]  core_state,
    input  wire logic [31:0] exec_pc,
    input  wire logic [31:0] next_pc,
    input  wire logic        bkpt_hit,
    input  wire logic        wpt_hit,
    input  wire logic        pabort,
    input  wire logic        dabort,
    input  wire logic        irq_pending,
    input  wire logic        vec_fetched,
    input  wire logic        dbg_exec,
    input  wire logic        system_speed_select,
    input  wire logic        dbg_branch,
    input  wire logic [23:0] branch_offset,
    input  wire logic        sys_done,
    input  wire logic        sys_abort,
    input  wire logic        force_word,
    input  wire logic        restart,
    input  wire logic        flag_clr,
    output logic             halted,
    output logic [31:0]      pc,
    output logic [31:0]      ret_addr,
    output logic [1:0]       mode,
    output logic [1:0]       istate,
    output logic [2:0]       cause,
    output logic             pc_frozen,
    output logic             irq_disable,
    output logic             irq_seen,
    output logic             abort_seen,
    output logic             link_invalid,
    output logic             sys_busy
);

    ////////////////////////////////////////////////////////////////////////////
    // request pin synchroniser

    logic req_m_q;
    logic req_s_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_m_q <= 1'b0;
            req_s_q <= 1'b0;
        end else begin
            req_m_q <= ext_dbg_req;
            req_s_q <= req_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state

    dep_state_t  st_q, st_d;
    dep_istate_t is_q, is_d;
    dep_mode_t   md_q, md_d;
    dep_cause_t  cs_q, cs_d;
    logic [31:0] pc_q, pc_d;
    logic [31:0] ret_q, ret_d;
    logic        frz_q, frz_d;
    logic        idis_q, idis_d;
    logic        iseen_q, iseen_d;
    logic        aseen_q, aseen_d;
    logic        lnk_q, lnk_d;
    logic [31:0] addr_sz;
    logic [31:0] base;
    logic [31:0] adv;
    logic [31:0] br_off;

    always_comb begin
        st_d    = st_q;
        is_d    = is_q;
        md_d    = md_q;
        cs_d    = cs_q;
        pc_d    = pc_q;
        ret_d   = ret_q;
        frz_d   = frz_q;
        idis_d  = idis_q;
        iseen_d = iseen_q & ~flag_clr;
        aseen_d = aseen_q & ~flag_clr;
        lnk_d   = lnk_q;
        addr_sz = (core_state == IS_HALF) ? `DEP_HALF_ADDR : `DEP_WORD_ADDR;
        base    = exec_pc;
        adv     = `DEP_BKPT_WORD_ADV;
        br_off  = {{6{branch_offset[23]}}, branch_offset, 2'b00};
        case (st_q)
            ST_RUN: begin
                pc_d = exec_pc;
                is_d = dep_istate_t'(core_state);
                if (pabort && bkpt_hit) begin
                    md_d = MD_ABORT;
                    pc_d = PABT_VEC;
                end else if (wpt_hit && dabort) begin
                    aseen_d = 1'b1;
                    md_d    = MD_ABORT;
                    cs_d    = CS_WPT;
                    pc_d    = DABT_VEC;
                    st_d    = ST_WAITVEC;
                end else if (wpt_hit || bkpt_hit || req_s_q) begin
                    st_d   = ST_HALT;
                    idis_d = 1'b1;
                    if (wpt_hit) begin
                        cs_d = CS_WPT;
                        base = next_pc;
                    end else if (bkpt_hit) begin
                        cs_d = CS_BKPT;
                    end else begin
                        cs_d = CS_REQ;
                    end
                    if (core_state == IS_BYTE) begin
                        adv   = `DEP_BYTE_ADV;
                        frz_d = 1'b1;
                    end else if (bkpt_hit && !wpt_hit) begin
                        adv = (core_state == IS_HALF) ? `DEP_BKPT_HALF_ADV
                                                      : `DEP_BKPT_WORD_ADV;
                    end else begin
                        adv = addr_sz << 2;
                    end
                    if (irq_pending) begin
                        iseen_d = 1'b1;
                        md_d    = MD_IRQ;
                        base    = IRQ_VEC;
                        adv     = `DEP_VEC_ENTRY;
                        frz_d   = 1'b0;
                        is_d    = IS_WORD;
                    end
                    pc_d  = base + adv;
                    ret_d = base + adv - `DEP_BYTE_ADV;
                end
            end
            ST_WAITVEC: begin
                if (vec_fetched) begin
                    st_d   = ST_HALT;
                    idis_d = 1'b1;
                    is_d   = IS_WORD;
                    pc_d   = DABT_VEC + `DEP_VEC_ENTRY;
                end
            end
            ST_HALT: begin
                if (force_word) begin
                    frz_d = 1'b0;
                    is_d  = IS_WORD;
                end
                if (restart) begin
                    st_d   = ST_RUN;
                    idis_d = 1'b0;
                    md_d   = MD_PROG;
                    cs_d   = CS_NONE;
                    lnk_d  = 1'b0;
                end else if (dbg_exec && !frz_q) begin
                    if (system_speed_select) begin
                        st_d = ST_SYS;
                        cs_d = CS_SYS;
                    end else if (dbg_branch) begin
                        pc_d = pc_q + `DEP_DBG_STEP + br_off;
                    end else begin
                        pc_d = pc_q + `DEP_DBG_STEP;
                    end
                end
            end
            ST_SYS: begin
                if (sys_abort) begin
                    st_d    = ST_SYSABT;
                    md_d    = MD_ABORT;
                    aseen_d = 1'b1;
                    lnk_d   = 1'b1;
                end else if (sys_done) begin
                    st_d = ST_HALT;
                    pc_d = pc_q + `DEP_SYS_STEP;
                end
            end
            ST_SYSABT: begin
                st_d = ST_HALT;
                pc_d = pc_q + `DEP_SYS_STEP;
            end
            default: begin
                st_d = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q    <= ST_RUN;
            is_q    <= IS_WORD;
            md_q    <= MD_PROG;
            cs_q    <= CS_NONE;
            pc_q    <= `DEP_PC_RST;
            ret_q   <= `DEP_PC_RST;
            frz_q   <= 1'b0;
            idis_q  <= 1'b0;
            iseen_q <= 1'b0;
            aseen_q <= 1'b0;
            lnk_q   <= 1'b0;
        end else begin
            st_q    <= st_d;
            is_q    <= is_d;
            md_q    <= md_d;
            cs_q    <= cs_d;
            pc_q    <= pc_d;
            ret_q   <= ret_d;
            frz_q   <= frz_d;
            idis_q  <= idis_d;
            iseen_q <= iseen_d;
            aseen_q <= aseen_d;
            lnk_q   <= lnk_d;
        end
    end

    assign halted       = st_q[2];
    assign sys_busy     = st_q[3];
    assign pc           = pc_q;
    assign ret_addr     = ret_q;
    assign mode         = md_q;
    assign istate       = is_q;
    assign cause        = cs_q;
    assign pc_frozen    = frz_q;
    assign irq_disable  = idis_q;
    assign irq_seen     = iseen_q;
    assign abort_seen   = aseen_q;
    assign link_invalid = lnk_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic run_clean;
    assign run_clean = (st_q == ST_RUN) && !pabort && !irq_pending && !wpt_hit;

    a_bkpt_word_adv: assert property (run_clean && bkpt_hit && core_state == IS_WORD
        |=> halted && pc_q == $past(exec_pc) + 32'h0000_0010)
        else $error("breakpoint entry word advance wrong");
    a_bkpt_half_adv: assert property (run_clean && bkpt_hit && core_state == IS_HALF
        |=> halted && pc_q == $past(exec_pc) + 32'h0000_0008)
        else $error("breakpoint entry halfword advance wrong");
    a_halt_step_pc: assert property (st_q == ST_HALT && dbg_exec && !restart && !frz_q
        && !system_speed_select && !dbg_branch |=> pc_q == $past(pc_q) + 32'h0000_0004)
        else $error("debug instruction step wrong");
    a_wpt_next_pc: assert property ((st_q == ST_RUN) && wpt_hit && !dabort && !irq_pending
        && !pabort && core_state == IS_WORD |=> halted && pc_q == $past(next_pc) + 32'h0000_0010)
        else $error("watchpoint entry pc wrong");
    a_byte_entry_pc: assert property ((st_q == ST_RUN) && bkpt_hit && !wpt_hit && !pabort
        && !irq_pending && core_state == IS_BYTE
        |=> pc_q == $past(exec_pc) + 32'h0000_0004 ##0 ret_q == $past(exec_pc))
        else $error("bytecode entry pc wrong");
    a_frozen_hold: assert property (halted && frz_q && !force_word |=> $stable(pc_q))
        else $error("frozen pc moved");
    a_abort_defer: assert property ((st_q == ST_RUN) && wpt_hit && dabort && !pabort
        |=> !halted && md_q == MD_ABORT && st_q == ST_WAITVEC)
        else $error("aborted watchpoint halted early");
    a_vec_wait_hold: assert property (st_q == ST_WAITVEC && !vec_fetched
        |=> !halted && st_q == ST_WAITVEC)
        else $error("aborted watchpoint left vector wait early");
    a_vec_then_halt: assert property (st_q == ST_WAITVEC && vec_fetched
        |=> halted && md_q == MD_ABORT && aseen_q)
        else $error("aborted watchpoint not halted in abort mode");
    a_sys_five_adr: assert property (st_q == ST_SYS && sys_done && !sys_abort
        |=> halted && pc_q == $past(pc_q) + 32'h0000_0014)
        else $error("system speed access advance wrong");
    a_sys_abort_md: assert property (st_q == ST_SYS && sys_abort
        |=> !halted && md_q == MD_ABORT && lnk_q ##1 halted)
        else $error("aborted system access sequence wrong");
    a_pabort_wins: assert property ((st_q == ST_RUN) && pabort && bkpt_hit
        |=> !halted && md_q == MD_ABORT && pc_q == PABT_VEC)
        else $error("prefetch abort did not win");
    a_halt_irq_off: assert property ($rose(halted) |-> idis_q)
        else $error("interrupts not disabled in halt");
    a_irq_mode_kept: assert property ((st_q == ST_RUN) && irq_pending && !pabort && !dabort
        && (bkpt_hit || wpt_hit) |=> halted && md_q == MD_IRQ && iseen_q)
        else $error("pending interrupt mode not kept");
    a_speed_low_dbg: assert property (st_q == ST_HALT && dbg_exec && !restart
        && !system_speed_select |=> st_q != ST_SYS)
        else $error("low speed bit ran at system speed");

    c_bkpt_return: cover property (halted ##1 dbg_exec && dbg_branch ##1 restart);
    c_sys_access:  cover property (st_q == ST_SYS ##[1:8] halted);
    c_abort_wpt:   cover property (st_q == ST_WAITVEC ##[1:8] halted);

endmodule // dep_debug_entry

//--- rtl/dep_pkg.sv
// types for the debug entry and program counter block
// assumes no other package is needed
package dep_pkg;

    typedef enum logic [4:0] {
        ST_RUN     = 5'b00001,
        ST_WAITVEC = 5'b00010,
        ST_HALT    = 5'b00100,
        ST_SYS     = 5'b01000,
        ST_SYSABT  = 5'b10000
    } dep_state_t;

    typedef enum logic [1:0] {
        IS_WORD  = 2'b00,
        IS_HALF  = 2'b01,
        IS_BYTE  = 2'b10
    } dep_istate_t;

    typedef enum logic [1:0] {
        MD_PROG  = 2'b00,
        MD_IRQ   = 2'b01,
        MD_ABORT = 2'b10
    } dep_mode_t;

    typedef enum logic [2:0] {
        CS_NONE  = 3'b000,
        CS_BKPT  = 3'b001,
        CS_WPT   = 3'b010,
        CS_REQ   = 3'b011,
        CS_SYS   = 3'b100
    } dep_cause_t;

endpackage

//--- test/dep_dbg_model.sv
// debugger model: scans instructions into the halted core
// assumes the bench calls its tasks; signals change at the falling edge
`timescale 1ns/1ps

module dep_dbg_model (
    input  wire logic        core_clk,
    output logic             dbg_exec,
    output logic             system_speed_select,
    output logic             dbg_branch,
    output logic [23:0]      branch_offset,
    output logic             sys_done,
    output logic             sys_abort,
    output logic             force_word,
    output logic             restart
);
    initial begin
        {dbg_exec, dbg_branch, sys_done, sys_abort, force_word, restart} = 6'h00;
        system_speed_select = 1'b0;
        branch_offset = 24'h00_0000;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one scanned instruction, then the memory side for a system access
    task automatic step(input logic sys, input logic br, input logic [23:0] off,
                        input logic abt);
        @(negedge core_clk);
        dbg_exec = 1'b1;
        system_speed_select = sys;
        dbg_branch = br;
        branch_offset = off;
        @(negedge core_clk);
        dbg_exec = 1'b0;
        dbg_branch = 1'b0;
        system_speed_select = ~sys;
        branch_offset = ~off;
        if (sys) begin
            sys_abort = abt;
            sys_done = ~abt;
            @(negedge core_clk);
            {sys_abort, sys_done} = 2'b00;
        end
    endtask
    // rs high: leave debug, low: force word state
    task automatic pulse(input logic rs);
        @(negedge core_clk);
        restart = rs;
        force_word = ~rs;
        @(negedge core_clk);
        {restart, force_word} = 2'b00;
    endtask
endmodule // dep_dbg_model

//--- test/tb.sv
// bench for the debug entry block: entry causes, return branch, system access
// assumes dep_dbg_model plays the debugger on the scan side
`timescale 1ns/1ps

module tb;
    import dep_pkg::*;
    localparam logic [31:0] PV = 32'h0000_000C, DV = 32'h0000_0010, IV = 32'h0000_0018;
    localparam int EV[7] = '{1, 1, 2, 2, 3, 17, 1};
    localparam int ST[7] = '{0, 1, 0, 1, 0, 0, 2};
    localparam int SL[7] = '{0, 0, 1, 1, 1, 2, 0};
    localparam int AD[7] = '{16, 8, 16, 8, 16, 16, 4};
    localparam int CS[7] = '{1, 1, 2, 2, 2, 1, 1};
    localparam int MD[7] = '{0, 0, 0, 0, 0, 1, 0};
    logic core_clk, rst_n, ext_dbg_req, bkpt_hit, wpt_hit, pabort, dabort, irq_pending;
    logic vec_fetched, dbg_exec, system_speed_select, dbg_branch, sys_done, sys_abort;
    logic force_word, restart, flag_clr, halted, pc_frozen, irq_disable, irq_seen;
    logic abort_seen, link_invalid, sys_busy, prev_h;
    logic [1:0]  core_state, mode, istate;
    logic [2:0]  cause;
    logic [23:0] branch_offset;
    logic [31:0] exec_pc, next_pc, pc, ret_addr, base, exp_q[$];
    int          fails, checked, cyc, seed;

    dep_debug_entry #(.PABT_VEC(PV), .DABT_VEC(DV), .IRQ_VEC(IV)) i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .ext_dbg_req(ext_dbg_req),
        .core_state(core_state), .exec_pc(exec_pc), .next_pc(next_pc),
        .bkpt_hit(bkpt_hit), .wpt_hit(wpt_hit), .pabort(pabort), .dabort(dabort),
        .irq_pending(irq_pending), .vec_fetched(vec_fetched), .dbg_exec(dbg_exec),
        .system_speed_select(system_speed_select), .dbg_branch(dbg_branch),
        .branch_offset(branch_offset), .sys_done(sys_done), .sys_abort(sys_abort),
        .force_word(force_word), .restart(restart), .flag_clr(flag_clr),
        .halted(halted), .pc(pc), .ret_addr(ret_addr), .mode(mode), .istate(istate),
        .cause(cause), .pc_frozen(pc_frozen), .irq_disable(irq_disable),
        .irq_seen(irq_seen), .abort_seen(abort_seen), .link_invalid(link_invalid),
        .sys_busy(sys_busy));
    dep_dbg_model i_dbg (
        .core_clk(core_clk), .dbg_exec(dbg_exec), .system_speed_select(system_speed_select),
        .dbg_branch(dbg_branch), .branch_offset(branch_offset), .sys_done(sys_done),
        .sys_abort(sys_abort), .force_word(force_word), .restart(restart));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_of_test();
        if (fails == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // event bits: irq, dabort, pabort, wpt, bkpt
    task automatic fire(input logic [4:0] ev, input logic [1:0] st);
        @(negedge core_clk);
        {irq_pending, dabort, pabort, wpt_hit, bkpt_hit} = ev;
        core_state = st;
        @(negedge core_clk);
        {irq_pending, dabort, pabort, wpt_hit, bkpt_hit} = 5'h00;
    endtask
    // s system accesses, two nops, then the return branch
    task automatic ret_session(input logic [31:0] ent, input logic [31:0] tgt, input int s);
        for (int j = 0; j < s; j++) begin
            exp_q.push_back(ent + 32'(20 * (j + 1)));
            i_dbg.step(1'b1, 1'b0, 24'h00_0000, 1'b0);
        end
        i_dbg.step(1'b0, 1'b0, 24'h00_0000, 1'b0);
        chk("step_pc", pc, ent + 32'(20 * s + 4));
        i_dbg.step(1'b0, 1'b0, 24'h00_0000, 1'b0);
        i_dbg.step(1'b0, 1'b1, 24'(-(4 + 3 + 5 * s)), 1'b0);
        chk("return_pc", pc, tgt);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            end_of_test();
        end
    end
    // monitor: every entry into halt takes the oldest expected pc
    always @(negedge core_clk) begin
        if (halted === 1'b1 && prev_h !== 1'b1)
            chk("entry_pc", pc, (exp_q.size() > 0) ? exp_q.pop_front() : ~pc);
        prev_h = halted;
    end
    initial begin
        seed = 32'h647c_df6f;
        rst_n = 1'b0;
        {ext_dbg_req, bkpt_hit, wpt_hit, pabort, dabort, irq_pending} = 6'h00;
        {vec_fetched, flag_clr} = 2'b00;
        core_state = 2'b00;
        exec_pc = 32'h0000_0100;
        next_pc = 32'h0000_0104;
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        chk("reset_halted", 32'(halted), 32'h0000_0000);
        for (int k = 0; k < 7; k++) begin
            @(negedge core_clk);
            exec_pc = {$random(seed)} & 32'h000f_fffc;
            next_pc = exec_pc + 32'h0000_0004;
            base = (SL[k] == 2) ? IV : (SL[k] == 1) ? next_pc : exec_pc;
            exp_q.push_back(base + 32'(AD[k]));
            fire(5'(EV[k]), 2'(ST[k]));
            chk("cause", 32'(cause), 32'(CS[k]));
            chk("mode", 32'(mode), 32'(MD[k]));
            chk("istate", 32'(istate), 32'(ST[k]));
            chk("irq_disable", 32'(irq_disable), 32'h0000_0001);
            if (MD[k] == 1)
                chk("irq_seen", 32'(irq_seen), 32'h0000_0001);
            if (ST[k] == 2) begin
                chk("ret_addr", ret_addr, exec_pc);
                i_dbg.step(1'b0, 1'b0, 24'h00_0000, 1'b0);
                chk("frozen_pc", pc, exec_pc + 32'h0000_0004);
                i_dbg.pulse(1'b0);
                chk("pc_frozen", 32'(pc_frozen), 32'h0000_0000);
                chk("istate_word", 32'(istate), 32'h0000_0000);
            end
            if (ST[k] == 0)
                ret_session(base + 32'(AD[k]), base, (k == 0) ? 1 : 0);
            i_dbg.pulse(1'b1);
        end
        exp_q.push_back(exec_pc + 32'h0000_0010);
        core_state = 2'b00;
        ext_dbg_req = 1'b1;
        repeat (2) @(negedge core_clk);
        chk("req_early", 32'(halted), 32'h0000_0000);
        @(negedge core_clk);
        ext_dbg_req = 1'b0;
        chk("req_cause", 32'(cause), 32'h0000_0003);
        ret_session(exec_pc + 32'h0000_0010, exec_pc, 0);
        exp_q.push_back(exec_pc + 32'h0000_0014);
        i_dbg.step(1'b1, 1'b0, 24'h00_0000, 1'b1);
        chk("sys_abt_mode", 32'(mode), 32'h0000_0002);
        chk("link_invalid", 32'(link_invalid), 32'h0000_0001);
        i_dbg.pulse(1'b1);
        exp_q.push_back(DV + 32'h0000_0010);
        fire(5'h0a, 2'b00);
        chk("wait_vec", 32'(halted), 32'h0000_0000);
        chk("abort_seen", 32'(abort_seen), 32'h0000_0001);
        @(negedge core_clk);
        chk("vec_hold", 32'(halted), 32'h0000_0000);
        vec_fetched = 1'b1;
        @(negedge core_clk);
        vec_fetched = 1'b0;
        chk("wpt_abt_mode", 32'(mode), 32'h0000_0002);
        flag_clr = 1'b1;
        @(negedge core_clk);
        flag_clr = 1'b0;
        chk("abort_clr", 32'(abort_seen), 32'h0000_0000);
        ret_session(DV + 32'h0000_0010, DV, 0);
        i_dbg.pulse(1'b1);
        fire(5'h05, 2'b00);
        chk("pabt_halt", 32'(halted), 32'h0000_0000);
        chk("pabt_pc", pc, PV);
        chk("queue_left", 32'(exp_q.size()), 32'h0000_0000);
        end_of_test();
    end
endmodule // tb
